// ### verilog/sld_top.sv
// Signal loss detector control: serial register slave, threshold coding,
// hysteresis on the loss flag, power-down and single-shot level capture.
// Assumes the front end delivers the measured peak-to-peak level in mV,
// already digitised on the core clock, and an open-drain serial bus outside.
//
// Function
// - Flag asserts below threshold, clears only at twice the threshold or in power-down.
// - Loss detection uses absolute level, unaffected by any slice offset.
// - Detector on after reset; power-down bit 3 of control_b disables it.
// - Threshold 0 to 254 mV, loaded via level_data and strobe toggle, target 1.
// - Thresholds 0 to 63 mV use all bits, 1 mV per step.
// - Thresholds 64 to 254 mV force bit zero low, 2 mV steps.
// - Single-shot amplitude measurement triggered by writing 0x7, 0x17, 0x7.
// - Strobe falling during a measurement loads amplitude into level_data.
// - Hardware changes level_data only on strobe low-high-low with target 7.
// - Serial access: device address, subaddress, auto-increment until stop.
`timescale 1ns/1ps
`include "sld_map.svh"

module sld_top (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Serial register bus pins
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    input wire logic i_addr_sel,
    // Analogue front end
    input wire logic [7:0] i_level_mv,
    output logic o_signal_loss_flag,
    output logic o_detector_powerdown
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic scl;
    logic sda;
    logic addr_lsb;
    logic scl_prev_q;
    logic sda_prev_q;
    logic scl_rise, scl_fall;
    logic bus_start, bus_stop;
    sld_pkg::sld_i2c_state_t st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d;
    logic [7:0] tx_q, tx_d;
    logic oe_q, oe_d;
    logic [7:0] ptr_q, ptr_d;
    logic sub_q, sub_d;
    logic rw_q, rw_d;
    logic nack_q, nack_d;
    logic wr_en;
    logic [7:0] rdata;
    logic [7:0] ctrl_b_q, ctrl_b_d;
    logic [7:0] ldata_q, ldata_d;
    logic [7:0] lctrl_q, lctrl_d;
    logic [7:0] thr_q, thr_d;
    logic flag_q, flag_d;
    logic strobe_fall;
    logic [2:0] held_tgt;
    logic [7:0] eff_thr;
    logic [8:0] clear_lvl;

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    sld_pin_sync #(.RESET_VAL(1'b1)) u_sync_scl (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_pin(i_scl),
        .o_level(scl)
    );

    sld_pin_sync #(.RESET_VAL(1'b1)) u_sync_sda (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_pin(i_sda),
        .o_level(sda)
    );

    sld_pin_sync #(.RESET_VAL(1'b0)) u_sync_addr (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_pin(i_addr_sel),
        .o_level(addr_lsb)
    );

    // ------------------------------------------------------------------------
    // Bus events from filtered levels
    // ------------------------------------------------------------------------
    assign scl_rise = scl & ~scl_prev_q;
    assign scl_fall = ~scl & scl_prev_q;
    assign bus_start = scl & scl_prev_q & sda_prev_q & ~sda;
    assign bus_stop = scl & scl_prev_q & ~sda_prev_q & sda;

    // ------------------------------------------------------------------------
    // Serial slave next state
    // ------------------------------------------------------------------------
    // address then subaddress
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        tx_d = tx_q;
        oe_d = oe_q;
        ptr_d = ptr_q;
        sub_d = sub_q;
        rw_d = rw_q;
        nack_d = nack_q;
        wr_en = 1'b0;
        if (bus_stop) begin
            st_d = sld_pkg::SLD_ST_IDLE;
            oe_d = 1'b0;
        end else if (bus_start) begin
            st_d = sld_pkg::SLD_ST_ADDR;
            cnt_d = 4'h0;
            oe_d = 1'b0;
        end else begin
            case (st_q)
                sld_pkg::SLD_ST_ADDR: begin
                    if (scl_rise) begin
                        sh_d = {sh_q[6:0], sda};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == `SLD_BITS_PER_BYTE) begin
                        if (sh_q[7:1] == {`SLD_ADDR_UPPER, addr_lsb}) begin
                            st_d = sld_pkg::SLD_ST_ADR_ACK;
                            oe_d = 1'b1;
                            rw_d = sh_q[0];
                        end else begin
                            st_d = sld_pkg::SLD_ST_IDLE;
                        end
                    end
                end
                sld_pkg::SLD_ST_ADR_ACK: begin
                    if (scl_fall) begin
                        cnt_d = 4'h0;
                        if (rw_q) begin
                            st_d = sld_pkg::SLD_ST_TX;
                            tx_d = rdata;
                            oe_d = ~rdata[7];
                        end else begin
                            st_d = sld_pkg::SLD_ST_RX;
                            oe_d = 1'b0;
                            sub_d = 1'b1;
                        end
                    end
                end
                sld_pkg::SLD_ST_RX: begin
                    if (scl_rise) begin
                        sh_d = {sh_q[6:0], sda};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == `SLD_BITS_PER_BYTE) begin
                        st_d = sld_pkg::SLD_ST_RX_ACK;
                        oe_d = 1'b1;
                        if (sub_q) begin
                            ptr_d = sh_q;
                            sub_d = 1'b0;
                        end else begin
                            wr_en = 1'b1;
                            ptr_d = ptr_q + 8'h01;
                        end
                    end
                end
                sld_pkg::SLD_ST_RX_ACK: begin
                    if (scl_fall) begin
                        st_d = sld_pkg::SLD_ST_RX;
                        oe_d = 1'b0;
                        cnt_d = 4'h0;
                    end
                end
                sld_pkg::SLD_ST_TX: begin
                    if (scl_rise) begin
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_q == `SLD_BITS_PER_BYTE) begin
                            st_d = sld_pkg::SLD_ST_TX_ACK;
                            oe_d = 1'b0;
                            ptr_d = ptr_q + 8'h01;
                        end else begin
                            tx_d = {tx_q[6:0], 1'b0};
                            oe_d = ~tx_q[6];
                        end
                    end
                end
                sld_pkg::SLD_ST_TX_ACK: begin
                    if (scl_rise) begin
                        nack_d = sda;
                    end else if (scl_fall) begin
                        if (!nack_q) begin
                            st_d = sld_pkg::SLD_ST_TX;
                            cnt_d = 4'h0;
                            tx_d = rdata;
                            oe_d = ~rdata[7];
                        end else begin
                            st_d = sld_pkg::SLD_ST_IDLE;
                        end
                    end
                end
                default: begin
                    st_d = sld_pkg::SLD_ST_IDLE;
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    // Serial slave registers
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            st_q <= sld_pkg::SLD_ST_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            oe_q <= 1'b0;
            ptr_q <= 8'h00;
            sub_q <= 1'b0;
            rw_q <= 1'b0;
            nack_q <= 1'b0;
        end else begin
            scl_prev_q <= scl;
            sda_prev_q <= sda;
            st_q <= st_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            tx_q <= tx_d;
            oe_q <= oe_d;
            ptr_q <= ptr_d;
            sub_q <= sub_d;
            rw_q <= rw_d;
            nack_q <= nack_d;
        end
    end

    // Open-drain data pin: only ever pulls low
    assign o_sda_out = 1'b0;
    assign o_sda_oe = oe_q;

    // ------------------------------------------------------------------------
    // Register read mux, unmapped subaddresses read as zero
    // ------------------------------------------------------------------------
    always_comb begin
        case (ptr_q)
            `SLD_OFS_CONTROL_B: rdata = ctrl_b_q;
            `SLD_OFS_LEVEL_DATA: rdata = ldata_q;
            `SLD_OFS_LEVEL_CONTROL: rdata = lctrl_q;
            default: rdata = `SLD_READ_FILL;
        endcase
    end

    // ------------------------------------------------------------------------
    // Register file and strobe sequencing
    // ------------------------------------------------------------------------
    // Strobe falls when a write clears a set strobe bit
    assign strobe_fall = wr_en && ptr_q == `SLD_OFS_LEVEL_CONTROL
                         && lctrl_q[`SLD_BIT_WRITE_STROBE] && !sh_q[`SLD_BIT_WRITE_STROBE];
    // Target that stood while the strobe was high
    assign held_tgt = lctrl_q[`SLD_TGT_MSB:`SLD_TGT_LSB];

    always_comb begin
        ctrl_b_d = ctrl_b_q;
        ldata_d = ldata_q;
        lctrl_d = lctrl_q;
        thr_d = thr_q;
        if (wr_en) begin
            case (ptr_q)
                `SLD_OFS_CONTROL_B: ctrl_b_d = sh_q;
                `SLD_OFS_LEVEL_DATA: ldata_d = sh_q;
                `SLD_OFS_LEVEL_CONTROL: lctrl_d = sh_q;
                default: ctrl_b_d = ctrl_b_q;
            endcase
        end
        if (strobe_fall && held_tgt == `SLD_TGT_THRESHOLD) begin
            thr_d = ldata_q;
        end
        if (strobe_fall && held_tgt == `SLD_TGT_MEASURE) begin
            ldata_d = i_level_mv;
        end
    end

    // Register file registers
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            ctrl_b_q <= `SLD_RST_CONTROL_B;
            ldata_q <= `SLD_RST_LEVEL_DATA;
            lctrl_q <= `SLD_RST_LEVEL_CONTROL;
            thr_q <= `SLD_RST_THRESHOLD;
        end else begin
            ctrl_b_q <= ctrl_b_d;
            ldata_q <= ldata_d;
            lctrl_q <= lctrl_d;
            thr_q <= thr_d;
        end
    end

    // ------------------------------------------------------------------------
    // Threshold coding and loss flag hysteresis
    // ------------------------------------------------------------------------
    // two resolution ranges
    assign eff_thr = (thr_q < `SLD_COARSE_START) ? thr_q : {thr_q[7:1], 1'b0};
    assign clear_lvl = {eff_thr, 1'b0};

    always_comb begin
        flag_d = flag_q;
        if (ctrl_b_q[`SLD_BIT_POWERDOWN]) begin
            flag_d = 1'b0;
        end else if (i_level_mv < eff_thr) begin
            flag_d = 1'b1;
        end else if ({1'b0, i_level_mv} >= clear_lvl) begin
            flag_d = 1'b0;
        end
    end

    // Flag register
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign o_signal_loss_flag = flag_q;
    assign o_detector_powerdown = ctrl_b_q[`SLD_BIT_POWERDOWN];

endmodule

// ### verilog/sld_map.svh
// Register map, field positions, reset values and codes of the signal loss detector.
// Assumes inclusion by bare name from the design files of this block.
`ifndef SLD_MAP_SVH
`define SLD_MAP_SVH

// ----------------------------------------------------------------------------
// Register subaddresses
// ----------------------------------------------------------------------------
`define SLD_OFS_CONTROL_B 8'h09
`define SLD_OFS_LEVEL_DATA 8'h36
`define SLD_OFS_LEVEL_CONTROL 8'h74

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SLD_BIT_POWERDOWN 3
`define SLD_BIT_WRITE_STROBE 4
`define SLD_TGT_MSB 2
`define SLD_TGT_LSB 0

// ----------------------------------------------------------------------------
// Target select codes
// ----------------------------------------------------------------------------
`define SLD_TGT_THRESHOLD 3'h1
`define SLD_TGT_MEASURE 3'h7

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SLD_RST_CONTROL_B 8'h00
`define SLD_RST_LEVEL_DATA 8'h00
`define SLD_RST_LEVEL_CONTROL 8'h00
`define SLD_RST_THRESHOLD 8'h00

// ----------------------------------------------------------------------------
// Threshold coding and serial bus constants
// ----------------------------------------------------------------------------
`define SLD_COARSE_START 8'h40
`define SLD_ADDR_UPPER 6'h20
`define SLD_BITS_PER_BYTE 4'h8
`define SLD_READ_FILL 8'h00

`endif

// ### verilog/sld_pkg.sv
// Types shared by the signal loss detector design files.
// Assumes nothing of its surroundings.
package sld_pkg;

    // ------------------------------------------------------------------------
    // Serial slave states, Gray coded along the usual path
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        SLD_ST_IDLE    = 3'h0,
        SLD_ST_ADDR    = 3'h1,
        SLD_ST_ADR_ACK = 3'h3,
        SLD_ST_RX      = 3'h2,
        SLD_ST_RX_ACK  = 3'h6,
        SLD_ST_TX      = 3'h7,
        SLD_ST_TX_ACK  = 3'h5
    } sld_i2c_state_t;

endpackage

// ### verilog/sld_pin_sync.sv
// Three-stage pin synchroniser with an agreement filter.
// Assumes an asynchronous pin input and the core clock with synchronous reset.
`timescale 1ns/1ps

module sld_pin_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Pin and filtered level
    input wire logic i_pin,
    output logic o_level
);

    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;
    logic s1_d;
    logic s2_d;
    logic s3_d;
    logic lvl_d;

    // ------------------------------------------------------------------------
    // Next values: a change counts once stages two and three agree
    // ------------------------------------------------------------------------
    always_comb begin
        s1_d = i_pin;
        s2_d = s1_q;
        s3_d = s2_q;
        lvl_d = lvl_q;
        if (s2_q == s3_q) begin
            lvl_d = s3_q;
        end
    end

    // Registers
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            s1_q <= RESET_VAL;
            s2_q <= RESET_VAL;
            s3_q <= RESET_VAL;
            lvl_q <= RESET_VAL;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            lvl_q <= lvl_d;
        end
    end

    assign o_level = lvl_q;

endmodule

// ### sim/sld_i2c_host.sv
// I2C host model: paces SCL and pulls SDA low.
// Assumes a pull-up on SDA that the bench resolves.
`timescale 1ns/1ps

module sld_i2c_host #(
    parameter logic [7:0] DEV_W = 8'h82
) (
    // Clock and wire level
    input wire logic i_core_clk,
    input wire logic i_sda,
    // Pins driven
    output logic o_scl,
    output logic o_sda_low
);
    // ----
    // Bus timing
    // ----
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end

    // Ten clocks keep the pin filter happy
    task automatic half();
        repeat (10) @(negedge i_core_clk);
    endtask

    task automatic start();
        o_sda_low = 1'b0;
        half();
        o_scl = 1'b1;
        half();
        o_sda_low = 1'b1;
        half();
        o_scl = 1'b0;
        half();
    endtask

    task automatic stop();
        o_sda_low = 1'b1;
        half();
        o_scl = 1'b1;
        half();
        o_sda_low = 1'b0;
        half();
    endtask

    // bit sampled late in SCL high
    task automatic bit_io(input logic b, output logic r);
        o_sda_low = !b;
        half();
        o_scl = 1'b1;
        half();
        r = i_sda;
        o_scl = 1'b0;
        half();
    endtask

    // bytes MSB first, ninth bit ack
    task automatic xfer(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(ack_in, ack);
    endtask

    task automatic wr_reg(input logic [7:0] sub, input logic [7:0] d, output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2;
        start();
        xfer(DEV_W, 1'b1, rx, a0);
        xfer(sub, 1'b1, rx, a1);
        xfer(d, 1'b1, rx, a2);
        stop();
        ok = !(a0 | a1 | a2);
    endtask

    task automatic rd_reg(input logic [7:0] sub, output logic [7:0] d);
        logic [7:0] rx;
        logic a;
        start();
        xfer(DEV_W, 1'b1, rx, a);
        xfer(sub, 1'b1, rx, a);
        start();
        xfer(DEV_W | 8'h01, 1'b1, rx, a);
        xfer(8'hff, 1'b1, d, a);
        stop();
    endtask
endmodule

// ### sim/sld_top_asserts.sv
// Port checks for the signal loss detector top.
// Assumes a bind onto sld_top and host timing of 10 clocks a half bit.
`timescale 1ns/1ps

module sld_top_asserts (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Serial pins
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic o_sda_out,
    input wire logic o_sda_oe,
    input wire logic i_addr_sel,
    // Front end
    input wire logic [7:0] i_level_mv,
    input wire logic o_signal_loss_flag,
    input wire logic o_detector_powerdown
);
    logic [7:0] rise_lvl_q, rise_lvl_d, lvl_q;
    logic flag_q;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    // Level that made the flag rise
    always_comb begin
        rise_lvl_d = (o_signal_loss_flag && !flag_q) ? lvl_q : rise_lvl_q;
    end

    always_ff @(posedge i_core_clk) begin
        lvl_q <= i_level_mv;
        flag_q <= i_rst_n && o_signal_loss_flag;
        rise_lvl_q <= i_rst_n ? rise_lvl_d : 8'h00;
    end

    // ----
    // Checks
    // ----
    reset_clears_a: assert property ($rose(i_rst_n) |-> !o_signal_loss_flag
        && !o_sda_oe && !o_detector_powerdown) else $error("outputs not cleared");
    pd_clears_flag_a: assert property (o_detector_powerdown |=>
        !o_signal_loss_flag) else $error("flag set in power-down");
    pd_write_time_a: assert property ($changed(o_detector_powerdown) |->
        !i_scl) else $error("power-down moved with SCL high");
    sda_pull_only_a: assert property (o_sda_out == 1'b0)
        else $error("SDA driven high");
    oe_scl_low_a: assert property ($changed(o_sda_oe) |-> !i_scl)
        else $error("SDA moved with SCL high");
    oe_holds_a: assert property ($changed(o_sda_oe) |=> $stable(o_sda_oe)[*5])
        else $error("SDA bit too short");
    rise_below_a: assert property ($rose(o_signal_loss_flag) |->
        !$past(o_detector_powerdown) && $past(i_level_mv) < 8'hfe)
        else $error("flag rose without low level");
    fall_twice_a: assert property ($fell(o_signal_loss_flag)
        && !$past(o_detector_powerdown) |->
        {2'b00, $past(i_level_mv)} >= (({2'b00, rise_lvl_q} + 10'h001) << 1))
        else $error("flag cleared below twice threshold");
endmodule

// ### sim/sld_top_test.sv
// Bench for the signal loss detector top.
// Assumes the host model and checker files compile before it.
`timescale 1ns/1ps
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin \
    num_errors++; $display("mismatch %s exp %h got %h", what, exp, got); end end

module sld_top_test;
    logic clk, rst_n, scl, sda_low, sda_oe, sda_out, addr_sel, flag, pd;
    logic [7:0] level;
    wire logic sda;
    int num_errors = 0;
    int compares = 0;

    // Open-drain SDA with pull-up
    assign sda = (sda_oe ? sda_out : 1'b1) & !sda_low;

    sld_top dut_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda),
        .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_addr_sel(addr_sel),
        .i_level_mv(level), .o_signal_loss_flag(flag), .o_detector_powerdown(pd));

    sld_i2c_host host_u (.i_core_clk(clk), .i_sda(sda), .o_scl(scl),
        .o_sda_low(sda_low));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ----
    // Helpers
    // ----
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] sub, input logic [7:0] d);
        logic ok;
        host_u.wr_reg(sub, d, ok);
        `CHK("write ack", 1'b1, ok)
    endtask

    task automatic rd_chk(input logic [7:0] sub, input logic [7:0] e, input string n);
        logic [7:0] v;
        host_u.rd_reg(sub, v);
        `CHK(n, e, v)
    endtask

    task automatic lvl(input logic [7:0] v, input logic e);
        level = v;
        repeat (3) @(negedge clk);
        `CHK("loss flag", e, flag)
    endtask

    // ----
    // Scenarios
    // ----
    task automatic t_reset();
        rd_chk(8'h09, 8'h00, "control_b");
        rd_chk(8'h36, 8'h00, "level_data");
        rd_chk(8'h74, 8'h00, "level_control");
        rd_chk(8'h50, 8'h00, "unmapped");
        lvl(8'h00, 1'b0);
        `CHK("powerdown", 1'b0, pd)
        $display("test reset done");
    endtask

    task automatic t_bus();
        logic [7:0] rx;
        logic ack;
        host_u.start();
        host_u.xfer(8'h80, 1'b1, rx, ack);
        host_u.stop();
        `CHK("foreign address nack", 1'b1, ack)
        host_u.start();
        host_u.xfer(8'h82, 1'b1, rx, ack);
        host_u.xfer(8'h35, 1'b1, rx, ack);
        host_u.xfer(8'h11, 1'b1, rx, ack);
        host_u.xfer(8'ha5, 1'b1, rx, ack);
        host_u.stop();
        rd_chk(8'h36, 8'ha5, "auto increment");
        $display("test bus done");
    endtask

    task automatic t_thr(input logic [7:0] thr);
        logic [7:0] eff;
        eff = (thr < 8'h40) ? thr : {thr[7:1], 1'b0};
        wr(8'h74, 8'h21);
        wr(8'h36, thr);
        wr(8'h74, 8'h31);
        wr(8'h74, 8'h21);
        lvl(8'hff, 1'b0);
        lvl(eff, 1'b0);
        lvl(eff - 8'h01, 1'b1);
        lvl((eff << 1) - 8'h01, 1'b1);
        lvl(eff << 1, 1'b0);
        $display("test threshold %0d done", thr);
    endtask

    task automatic t_target();
        wr(8'h74, 8'h22);
        wr(8'h36, 8'h0a);
        wr(8'h74, 8'h32);
        wr(8'h74, 8'h22);
        lvl(8'h3f, 1'b1);
        lvl(8'hff, 1'b0);
        rd_chk(8'h36, 8'h0a, "host data kept");
        $display("test target done");
    endtask

    task automatic t_pd();
        lvl(8'h00, 1'b1);
        wr(8'h09, 8'h08);
        repeat (3) @(negedge clk);
        `CHK("powerdown", 1'b1, pd)
        `CHK("flag off", 1'b0, flag)
        rd_chk(8'h09, 8'h08, "control_b");
        wr(8'h09, 8'h00);
        lvl(8'h00, 1'b1);
        lvl(8'hff, 1'b0);
        $display("test powerdown done");
    endtask

    task automatic t_meas();
        level = 8'h5a;
        wr(8'h74, 8'h07);
        wr(8'h74, 8'h17);
        level = 8'h3c;
        wr(8'h74, 8'h07);
        rd_chk(8'h36, 8'h3c, "measured level");
        level = 8'h11;
        wr(8'h74, 8'h07);
        rd_chk(8'h36, 8'h3c, "level held");
        $display("test measure done");
    endtask

    // Second reset mid-run: registers and threshold cleared, address strap re-read
    task automatic t_rerun();
        logic [7:0] rx;
        logic ack;
        wr(8'h09, 8'h08);
        rst_n = 1'b0;
        addr_sel = 1'b0;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        `CHK("powerdown", 1'b0, pd)
        `CHK("flag", 1'b0, flag)
        host_u.start();
        host_u.xfer(8'h80, 1'b1, rx, ack);
        host_u.stop();
        `CHK("strap address ack", 1'b0, ack)
        addr_sel = 1'b1;
        rd_chk(8'h09, 8'h00, "control_b");
        rd_chk(8'h36, 8'h00, "level_data");
        lvl(8'h00, 1'b0);
        $display("test reset rerun done");
    endtask

    // Main sequence
    initial begin
        rst_n = 1'b0;
        addr_sel = 1'b1;
        level = 8'hff;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_reset();
        t_bus();
        t_thr(8'h0a);
        t_thr(8'h3f);
        t_thr(8'h41);
        t_target();
        t_pd();
        t_meas();
        t_rerun();
        close_out();
    end

    // Watchdog: the run needs about 35,200 clocks, so 60,000 is ample
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        close_out();
    end
endmodule

bind sld_top sld_top_asserts chk_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
    .i_addr_sel(i_addr_sel), .i_level_mv(i_level_mv),
    .o_signal_loss_flag(o_signal_loss_flag), .o_detector_powerdown(o_detector_powerdown));
